// file: core/dmc_map.svh
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH

// ==========================================================
// Address split
`define DMC_ADDR_W      22
`define DMC_LABEL_W     9
`define DMC_IDX_W       12
`define DMC_ENTRIES     4096
`define DMC_LABEL_LSB   13
`define DMC_IDX_LSB     1

// ==========================================================
// Register port
`define DMC_REG_CTRL    4'h0
`define DMC_REG_STAT    4'h4
`define DMC_CTRL_MASK   16'h06FF
`define DMC_CTRL_RST    16'h0000

// ==========================================================
// Control word bits
`define DMC_C_NOINTR    0
`define DMC_C_DIAG      1
`define DMC_C_FMISS0    2
`define DMC_C_FMISS1    3
`define DMC_C_BADDATA   6
`define DMC_C_ABORT     7
`define DMC_C_FLUSH     8
`define DMC_C_BYPASS    9
`define DMC_C_BADTAG    10

// ==========================================================
// Status word bits
`define DMC_S_CPERR     0
`define DMC_S_MPERR     1
`define DMC_S_FLUSHING  2

// ==========================================================
// Bus parity lines, vector, timing
`define DMC_BUS_PERR    16
`define DMC_BUS_PEN     17
`define DMC_VEC_PARITY  16'h004C
`define DMC_FLUSH_NS    1000000
`define DMC_CLK_NS      10

`endif

// file: core/dmc_pkg.sv
package dmc_pkg;

    // ======================================================
    // Request carriers
    typedef struct packed {
        logic        we;
        logic        byte_op;
        logic        bypass;
        logic [21:0] addr;
        logic [15:0] wdata;
    } dmc_cpu_req_t;

    typedef struct packed {
        logic        we;
        logic        byte_op;
        logic [21:0] addr;
        logic [15:0] wdata;
    } dmc_mem_req_t;

    typedef struct packed {
        logic        we;
        logic [21:0] addr;
    } dmc_dma_t;

    // ======================================================
    // Entry stores
    typedef struct packed {
        logic       valid;
        logic       tpar;
        logic [8:0] tag;
    } dmc_tag_t;

    typedef struct packed {
        logic       p1;
        logic [7:0] b1;
        logic       p0;
        logic [7:0] b0;
    } dmc_data_t;

    typedef enum logic [1:0] {
        DMC_FLUSH,
        DMC_IDLE,
        DMC_LOOK,
        DMC_MEM
    } dmc_state_t;

endpackage

// file: core/dmc_cache.sv
`include "dmc_map.svh"
`timescale 1ns/100ps
module dmc_cache
    import dmc_pkg::*;
#(
    parameter int FLUSH_CYCLES = `DMC_FLUSH_NS / `DMC_CLK_NS
)(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Register port
    input  wire logic [3:0]    reg_addr,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [15:0]        reg_rdata,
    // Console
    input  wire logic          console_start,
    // Processor side
    input  wire logic          cpu_valid,
    input  dmc_cpu_req_t       cpu_req,
    output logic               cpu_ready,
    output logic               cpu_done,
    output logic               cpu_hit,
    output logic [15:0]        cpu_rdata,
    // Memory side
    output logic               mem_req,
    output dmc_mem_req_t       mem_cmd,
    input  wire logic          mem_done,
    input  wire logic          mem_nxm,
    input  wire logic [15:0]   mem_rdata,
    // Bus parity sampling
    input  wire logic          bus_data_in_strobe,
    input  wire logic [21:0]   bus_data_address_lines,
    // DMA snoop
    input  wire logic          dma_valid,
    input  dmc_dma_t           dma_cmd,
    output logic               dma_ready,
    // Traps
    output logic               abort_req,
    output logic               intr_req,
    output logic               nxm_trap,
    output logic [15:0]        trap_vector
);

    localparam int IDX_W     = `DMC_IDX_W;
    localparam int ENTRIES   = `DMC_ENTRIES;
    localparam int FLUSH_LEN = (FLUSH_CYCLES > ENTRIES) ?
                               FLUSH_CYCLES : ENTRIES;
    localparam int FC_W      = $clog2(FLUSH_LEN + 1);

    // ======================================================
    // Parity helpers
    function automatic dmc_data_t mk_data(input logic [15:0] w,
                                          input logic        bad);
        dmc_data_t d;
        d.b0 = w[7:0];
        d.b1 = w[15:8];
        d.p0 = (^w[7:0]) ^ bad;
        d.p1 = (~^w[15:8]) ^ bad;
        return d;
    endfunction

    // ======================================================
    // State
    dmc_state_t       state_ff;
    dmc_cpu_req_t     req_ff;
    logic [15:0]      ctrl_ff;
    logic             cperr_ff;
    logic             mperr_ff;
    logic             flush_pend_ff;
    logic [FC_W-1:0]  flush_cnt_ff;
    logic             alloc_ff;
    logic             wthru_ff;
    logic             inv_ff;
    logic             strobe_ff;
    logic             done_ff;
    logic             hit_ff;
    logic [15:0]      rdata_ff;
    logic [15:0]      reg_rdata_ff;
    logic             abort_ff;
    logic             intr_ff;
    logic             nxm_ff;
    dmc_tag_t         tag_mem_ff  [ENTRIES];
    dmc_data_t        data_mem_ff [ENTRIES];

    // ======================================================
    // Lookup
    logic [8:0]       lbl_q;
    logic [IDX_W-1:0] idx_q;
    dmc_tag_t         tag_rd;
    dmc_data_t        dat_rd;
    logic             tag_match;
    logic             perr_now;
    logic             force_q;
    logic             byp_q;
    logic             io_q;
    logic             hit_q;
    logic             cperr_evt;
    logic             mperr_evt;
    logic             accept;
    logic             look;
    logic             fin;
    logic             flush_start;
    logic             flush_end;

    assign lbl_q  = req_ff.addr[21:`DMC_LABEL_LSB];
    assign idx_q  = req_ff.addr[`DMC_LABEL_LSB-1:`DMC_IDX_LSB];
    assign tag_rd = tag_mem_ff[idx_q];
    assign dat_rd = data_mem_ff[idx_q];
    assign force_q = ctrl_ff[`DMC_C_FMISS0] | ctrl_ff[`DMC_C_FMISS1];
    assign byp_q   = req_ff.bypass | ctrl_ff[`DMC_C_BYPASS];
    assign io_q    = &lbl_q;
    assign tag_match = tag_rd.valid && (tag_rd.tag == lbl_q);
    assign perr_now  = tag_rd.valid &&
                       ((^{tag_rd.tag, tag_rd.tpar}) ||
                        (tag_match && ((^{dat_rd.b0, dat_rd.p0}) ||
                                       !(^{dat_rd.b1, dat_rd.p1}))));
    assign hit_q = tag_match && !perr_now && !force_q && !io_q;
    assign look  = (state_ff == DMC_LOOK);
    assign cperr_evt = look && perr_now && !force_q && !io_q;
    assign accept = cpu_valid && cpu_ready;
    assign fin    = (state_ff == DMC_MEM) && mem_done;
    assign mperr_evt = strobe_ff && !bus_data_in_strobe &&
                       bus_data_address_lines[`DMC_BUS_PERR] &&
                       bus_data_address_lines[`DMC_BUS_PEN];

    // Flush triggers; bus reset is not one of them
    assign flush_start = console_start ||
                         (reg_wr && reg_addr == `DMC_REG_CTRL &&
                          reg_wdata[`DMC_C_FLUSH]);
    assign flush_end = (flush_cnt_ff == FC_W'(FLUSH_LEN - 1));

    // ======================================================
    // Control FSM
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= DMC_FLUSH;
        end else begin
            case (state_ff)
                DMC_FLUSH: begin
                    if (flush_end) begin
                        state_ff <= DMC_IDLE;
                    end
                end
                DMC_IDLE: begin
                    if (flush_pend_ff) begin
                        state_ff <= DMC_FLUSH;
                    end else if (accept) begin
                        state_ff <= DMC_LOOK;
                    end
                end
                DMC_LOOK: begin
                    if (!req_ff.we && hit_q && !byp_q) begin
                        state_ff <= DMC_IDLE;
                    end else begin
                        state_ff <= DMC_MEM;
                    end
                end
                DMC_MEM: begin
                    if (mem_done) begin
                        state_ff <= DMC_IDLE;
                    end
                end
                default: begin
                    state_ff <= DMC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_ff <= '0;
        end else if (accept) begin
            req_ff <= cpu_req;
        end
    end

    // Flush request and duration counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flush_pend_ff <= 1'b0;
            flush_cnt_ff  <= '0;
        end else begin
            if (flush_start) begin
                flush_pend_ff <= 1'b1;
            end else if (state_ff == DMC_FLUSH) begin
                flush_pend_ff <= 1'b0;
            end
            if (state_ff == DMC_FLUSH && !flush_end) begin
                flush_cnt_ff <= flush_cnt_ff + FC_W'(1);
            end else begin
                flush_cnt_ff <= '0;
            end
        end
    end

    // ======================================================
    // Decisions taken at lookup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alloc_ff <= 1'b0;
            wthru_ff <= 1'b0;
            inv_ff   <= 1'b0;
        end else if (look) begin
            alloc_ff <= !byp_q && !force_q && !io_q &&
                        !hit_q && !(req_ff.we && req_ff.byte_op);
            wthru_ff <= req_ff.we && hit_q && !byp_q;
            inv_ff   <= tag_match && !force_q && !io_q &&
                        (byp_q || (req_ff.we && req_ff.byte_op &&
                                   perr_now));
        end
    end

    // ======================================================
    // Entry store update
    dmc_tag_t  nxt_tag;
    dmc_data_t nxt_data;
    dmc_data_t wr_data;
    logic      tag_we;
    logic      data_we;
    logic      do_alloc;
    logic      dma_inv;
    logic [IDX_W-1:0] dma_idx;
    logic      bad_d;
    logic      bad_t;

    assign bad_d = ctrl_ff[`DMC_C_BADDATA];
    assign bad_t = ctrl_ff[`DMC_C_BADTAG];
    assign do_alloc = fin && alloc_ff &&
                      (!req_ff.we || !mem_nxm || ctrl_ff[`DMC_C_DIAG]);
    assign dma_idx = dma_cmd.addr[`DMC_LABEL_LSB-1:`DMC_IDX_LSB];
    assign dma_inv = dma_valid && dma_ready && dma_cmd.we &&
                     tag_mem_ff[dma_idx].valid &&
                     (tag_mem_ff[dma_idx].tag ==
                      dma_cmd.addr[21:`DMC_LABEL_LSB]);

    always_comb begin
        wr_data  = dat_rd;
        if (req_ff.byte_op && req_ff.addr[0]) begin
            wr_data = mk_data({req_ff.wdata[15:8], dat_rd.b0}, bad_d);
        end else if (req_ff.byte_op) begin
            wr_data = mk_data({dat_rd.b1, req_ff.wdata[7:0]}, bad_d);
        end else begin
            wr_data = mk_data(req_ff.wdata, bad_d);
        end
        nxt_tag  = tag_rd;
        nxt_data = dat_rd;
        tag_we   = 1'b0;
        data_we  = 1'b0;
        if (do_alloc) begin
            nxt_tag.valid = 1'b1;
            nxt_tag.tag   = lbl_q;
            nxt_tag.tpar  = (^lbl_q) ^ bad_t;
            nxt_data = req_ff.we ? mk_data(req_ff.wdata, bad_d) :
                                   mk_data(mem_rdata, bad_d);
            tag_we   = 1'b1;
            data_we  = 1'b1;
        end else if (fin && wthru_ff) begin
            nxt_data = wr_data;
            data_we  = 1'b1;
        end else if (fin && inv_ff) begin
            nxt_tag.valid = 1'b0;
            tag_we   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (state_ff == DMC_FLUSH) begin
            tag_mem_ff[flush_cnt_ff[IDX_W-1:0]]  <= '0;
            data_mem_ff[flush_cnt_ff[IDX_W-1:0]] <= mk_data(16'h0000,
                                                            1'b0);
        end else begin
            if (tag_we) begin
                tag_mem_ff[idx_q] <= nxt_tag;
            end
            if (data_we) begin
                data_mem_ff[idx_q] <= nxt_data;
            end
            if (dma_inv) begin
                tag_mem_ff[dma_idx].valid <= 1'b0;
            end
        end
    end

    // ======================================================
    // Processor answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_ff  <= 1'b0;
            hit_ff   <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            done_ff <= (look && !req_ff.we && hit_q && !byp_q) || fin;
            if (look && !req_ff.we && hit_q && !byp_q) begin
                hit_ff   <= 1'b1;
                rdata_ff <= {dat_rd.b1, dat_rd.b0};
            end else if (fin) begin
                hit_ff   <= wthru_ff;
                rdata_ff <= req_ff.we ? rdata_ff : mem_rdata;
            end
        end
    end

    // ======================================================
    // Control and status words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `DMC_CTRL_RST;
        end else if (console_start) begin
            ctrl_ff <= `DMC_CTRL_RST;
        end else if (reg_wr && reg_addr == `DMC_REG_CTRL) begin
            ctrl_ff <= reg_wdata & `DMC_CTRL_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cperr_ff <= 1'b0;
            mperr_ff <= 1'b0;
        end else begin
            if (cperr_evt) begin
                cperr_ff <= 1'b1;
            end else if (reg_wr && reg_addr == `DMC_REG_STAT &&
                         reg_wdata[`DMC_S_CPERR]) begin
                cperr_ff <= 1'b0;
            end
            if (mperr_evt) begin
                mperr_ff <= 1'b1;
            end else if (reg_wr && reg_addr == `DMC_REG_STAT &&
                         reg_wdata[`DMC_S_MPERR]) begin
                mperr_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 16'h0000;
        end else if (reg_rd && reg_addr == `DMC_REG_CTRL) begin
            reg_rdata_ff <= ctrl_ff;
        end else if (reg_rd && reg_addr == `DMC_REG_STAT) begin
            reg_rdata_ff <= {13'h0000, state_ff == DMC_FLUSH,
                             mperr_ff, cperr_ff};
        end else begin
            reg_rdata_ff <= 16'h0000;
        end
    end

    // ======================================================
    // Abort, interrupt and trap pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_ff <= 1'b0;
            abort_ff  <= 1'b0;
            intr_ff   <= 1'b0;
            nxm_ff    <= 1'b0;
        end else begin
            strobe_ff <= bus_data_in_strobe;
            abort_ff  <= mperr_evt ||
                         (cperr_evt && !cperr_ff &&
                          ctrl_ff[`DMC_C_ABORT]);
            intr_ff   <= cperr_evt && !cperr_ff &&
                         !ctrl_ff[`DMC_C_ABORT] &&
                         !ctrl_ff[`DMC_C_NOINTR];
            nxm_ff    <= fin && mem_nxm &&
                         !(req_ff.we && !req_ff.byte_op &&
                           ctrl_ff[`DMC_C_DIAG]);
        end
    end

    // ======================================================
    // Outputs
    assign cpu_ready   = (state_ff == DMC_IDLE) && !flush_pend_ff;
    assign dma_ready   = (state_ff != DMC_FLUSH);
    assign cpu_done    = done_ff;
    assign cpu_hit     = hit_ff;
    assign cpu_rdata   = rdata_ff;
    assign reg_rdata   = reg_rdata_ff;
    assign mem_req     = (state_ff == DMC_MEM);
    assign mem_cmd.we      = req_ff.we;
    assign mem_cmd.byte_op = req_ff.byte_op;
    assign mem_cmd.addr    = req_ff.addr;
    assign mem_cmd.wdata   = req_ff.wdata;
    assign abort_req   = abort_ff;
    assign intr_req    = intr_ff;
    assign nxm_trap    = nxm_ff;
    assign trap_vector = `DMC_VEC_PARITY;

    // ======================================================
    // Checks
    sequence s_write_taken;
        accept && cpu_req.we;
    endsequence

    sequence s_mem_issue;
        look ##1 mem_req;
    endsequence

    property p_write_mem;
        @(posedge clk) disable iff (rst)
        s_write_taken |=> s_mem_issue;
    endproperty
    a_write_mem: assert property (p_write_mem)
        else $error("write did not reach memory");

    property p_read_hit;
        @(posedge clk) disable iff (rst)
        (look && !req_ff.we && hit_q && !byp_q) |=>
            cpu_done && cpu_hit && !mem_req &&
            cpu_rdata == $past({dat_rd.b1, dat_rd.b0});
    endproperty
    a_read_hit: assert property (p_read_hit)
        else $error("read hit answer wrong");

    property p_io_miss;
        @(posedge clk) disable iff (rst)
        (look && io_q) |=> mem_req;
    endproperty
    a_io_miss: assert property (p_io_miss)
        else $error("I/O page reference served by cache");

    property p_force_quiet;
        @(posedge clk) disable iff (rst)
        (look && force_q) |=> !alloc_ff && !wthru_ff && !inv_ff;
    endproperty
    a_force_quiet: assert property (p_force_quiet)
        else $error("forced miss changed the cache");

    property p_alloc;
        @(posedge clk) disable iff (rst)
        do_alloc |=> tag_mem_ff[$past(idx_q)].valid &&
                     tag_mem_ff[$past(idx_q)].tag == $past(lbl_q);
    endproperty
    a_alloc: assert property (p_alloc)
        else $error("allocation did not fill entry");

    property p_byte_miss;
        @(posedge clk) disable iff (rst)
        (look && req_ff.we && req_ff.byte_op && !hit_q) |=> !alloc_ff;
    endproperty
    a_byte_miss: assert property (p_byte_miss)
        else $error("byte write miss allocated");

    property p_dma_inv;
        @(posedge clk) disable iff (rst)
        (dma_inv && !do_alloc) |=> !tag_mem_ff[$past(dma_idx)].valid;
    endproperty
    a_dma_inv: assert property (p_dma_inv)
        else $error("DMA write hit left entry valid");

    property p_mem_perr;
        @(posedge clk) disable iff (rst)
        mperr_evt |=> abort_req && mperr_ff;
    endproperty
    a_mem_perr: assert property (p_mem_perr)
        else $error("memory parity error did not abort");

    property p_repeat_quiet;
        @(posedge clk) disable iff (rst)
        (cperr_evt && cperr_ff && !mperr_evt) |=> !abort_req && !intr_req;
    endproperty
    a_repeat_quiet: assert property (p_repeat_quiet)
        else $error("repeated cache parity error trapped");

    property p_flush_block;
        @(posedge clk) disable iff (rst)
        (state_ff == DMC_FLUSH) |-> !dma_ready && !cpu_ready;
    endproperty
    a_flush_block: assert property (p_flush_block)
        else $error("service during flush");

endmodule

// file: tb/dmc_mem_model.sv
`timescale 1ns/100ps
module dmc_mem_model
    import dmc_pkg::*;
(
    // Clock and pacing
    input  wire logic        clk,
    input  wire logic [3:0]  lat,
    // Access channel
    input  wire logic        mem_req,
    input  dmc_mem_req_t     mem_cmd,
    output logic             mem_done,
    output logic             mem_nxm,
    output logic [15:0]      mem_rdata
);
    logic [15:0] mem [int];
    logic [3:0]  cnt = 4'h0;
    int          w;
    initial mem_done = 1'b0;
    initial mem_rdata = 16'h0000;
    assign mem_nxm = 1'b0;
    // ======================================================
    // Word store, data lines toggle outside the answer
    always @(posedge clk) begin
        w = int'(mem_cmd.addr[21:1]);
        mem_done <= mem_req && !mem_done && cnt == lat;
        cnt <= (mem_req && !mem_done && cnt != lat) ? cnt + 4'h1 : 4'h0;
        if (mem_req && !mem_done && cnt == lat) begin
            if (!mem.exists(w)) mem[w] = w[15:0] ^ 16'h5A5A;
            if (mem_cmd.we && !(mem_cmd.byte_op && mem_cmd.addr[0]))
                mem[w][7:0] = mem_cmd.wdata[7:0];
            if (mem_cmd.we && !(mem_cmd.byte_op && !mem_cmd.addr[0]))
                mem[w][15:8] = mem_cmd.wdata[15:8];
            mem_rdata <= mem[w];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import dmc_pkg::*;
    localparam logic [21:0] A = 22'h002468;
    localparam logic [21:0] B = 22'h00A001;
    localparam logic [21:0] IO = 22'h3FE010;
    logic clk, rst, reg_wr, reg_rd, console_start, cpu_valid, cpu_ready;
    logic cpu_done, cpu_hit, mem_req, mem_done, mem_nxm, strobe, dma_valid;
    logic dma_ready, abort_req, intr_req, nxm_trap;
    logic [3:0] reg_addr, lat;
    logic [15:0] reg_wdata, reg_rdata, cpu_rdata, mem_rdata, trap_vector;
    logic [21:0] lines;
    dmc_cpu_req_t cpu_req;
    dmc_mem_req_t mem_cmd;
    dmc_dma_t dma_cmd;
    int num_errors = 0;
    int cmp_count = 0;
    dmc_cache #(.FLUSH_CYCLES(4096)) dut (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .console_start(console_start), .cpu_valid(cpu_valid),
        .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_done(cpu_done),
        .cpu_hit(cpu_hit), .cpu_rdata(cpu_rdata), .mem_req(mem_req),
        .mem_cmd(mem_cmd), .mem_done(mem_done), .mem_nxm(mem_nxm),
        .mem_rdata(mem_rdata), .bus_data_in_strobe(strobe),
        .bus_data_address_lines(lines), .dma_valid(dma_valid),
        .dma_cmd(dma_cmd), .dma_ready(dma_ready), .abort_req(abort_req),
        .intr_req(intr_req), .nxm_trap(nxm_trap),
        .trap_vector(trap_vector));
    dmc_mem_model mem (.clk(clk), .lat(lat), .mem_req(mem_req),
        .mem_cmd(mem_cmd), .mem_done(mem_done), .mem_nxm(mem_nxm),
        .mem_rdata(mem_rdata));
    // ======================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rw(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rr(input logic [3:0] a, input logic [15:0] m, e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata & m, e);
    endtask
    task automatic cpu(input logic we, bt, input logic [21:0] a,
                       input logic [15:0] wd, input logic eh,
                       input logic [15:0] ed);
        int n;
        for (n = 0; cpu_ready !== 1'b1 && n < 9000; n++) @(negedge clk);
        @(posedge clk);
        cpu_valid <= 1'b1;
        cpu_req <= '{we, bt, 1'b0, a, wd};
        @(posedge clk);
        cpu_valid <= 1'b0;
        for (n = 0; cpu_done !== 1'b1 && n < 60; n++) @(negedge clk);
        chk(cpu_hit, eh);
        if (!we) chk(cpu_rdata, ed);
    endtask
    task automatic wrap_up;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ======================================================
    // Clock, watchdog, scenarios
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        num_errors++;
        wrap_up();
    end
    initial begin
        {rst, reg_wr, reg_rd, console_start, cpu_valid} = 5'b10000;
        {dma_valid, strobe, reg_addr, reg_wdata, lines} = '0;
        {cpu_req, dma_cmd} = '0;
        lat = 4'h1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        cpu(0, 0, A, 0, 0, A[16:1] ^ 16'h5A5A);
        cpu(0, 0, A, 0, 1, A[16:1] ^ 16'h5A5A);
        cpu(1, 0, A, 16'h1234, 1, 0);
        cpu(0, 0, A, 0, 1, 16'h1234);
        @(posedge clk);
        dma_valid <= 1'b1;
        dma_cmd <= '{1'b1, A};
        @(posedge clk);
        dma_valid <= 1'b0;
        cpu(0, 0, A, 0, 0, 16'h1234);
        rw(4'h0, 16'h0004);
        cpu(0, 0, A, 0, 0, 16'h1234);
        rw(4'h0, 16'h0000);
        cpu(0, 0, A, 0, 1, 16'h1234);
        rw(4'h0, 16'h0100);
        rr(4'h0, 16'hFFFF, 16'h0000);
        rr(4'h8, 16'hFFFF, 16'h0000);
        cpu(0, 0, A, 0, 0, 16'h1234);
        rw(4'h0, 16'h0040);
        cpu(1, 0, A, 16'h5555, 1, 0);
        rw(4'h0, 16'h0000);
        cpu(0, 0, A, 0, 0, 16'h5555);
        rr(4'h4, 16'h0001, 16'h0001);
        cpu(0, 0, A, 0, 1, 16'h5555);
        lat = 4'h6;
        cpu(1, 1, B, 16'hAB00, 0, 0);
        cpu(0, 0, B - 1, 0, 0, {8'hAB, B[8:1] ^ 8'h5A});
        cpu(0, 0, IO, 0, 0, IO[16:1] ^ 16'h5A5A);
        cpu(0, 0, IO, 0, 0, IO[16:1] ^ 16'h5A5A);
        @(posedge clk);
        strobe <= 1'b1;
        lines <= 22'h030000;
        @(posedge clk);
        strobe <= 1'b0;
        @(negedge clk);
        chk(abort_req, 1'b0);
        @(negedge clk);
        chk(abort_req, 1'b1);
        chk(trap_vector, 16'h004C);
        rr(4'h4, 16'h0002, 16'h0002);
        wrap_up();
    end
endmodule
